// ==== design/fsr_pkg.sv ====
// Purpose: Constants for the flash status polling controller
// Assumes: 8-bit flash data bus, 21-bit byte address
// Notes: Command register map is local to this controller
package fsr_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 8;
  // Wishbone register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  // Control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_RESET_CMD = 1;
  // Status bit positions on the flash data bus
  localparam int POLLING_BIT = 7;
  localparam int TOGGLE_BIT_ONE = 6;
  localparam int TIMEOUT_FAIL_BIT = 5;
  localparam int ERASE_TIMER_BIT = 3;
  localparam int TOGGLE_BIT_TWO = 2;
  // Status field indices, unused; REG_STAT packs done, fail, ready, busy from bit 0 up
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_RDY = 3;
  localparam logic [7:0] RESET_CMD = 8'hF0;
  // Bus cycle phase length
  localparam int CLK_MHZ = 250;
  localparam int STROBE_NS = 80;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [5:0] STROBE_CNT = 6'(STROBE_CYC);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_RD1 = 4'b0001,
    ST_RD2 = 4'b0010,
    ST_CHECK = 4'b0011,
    ST_RD3 = 4'b0100,
    ST_RD4 = 4'b0101,
    ST_RECHECK = 4'b0110,
    ST_WR = 4'b0111,
    ST_GAP = 4'b1000
  } fsr_state_t;
endpackage

// ==== design/fsr_poll_ctrl.sv ====
// Purpose: Host controller polling flash write status via toggle bits
// Assumes: Flash pins sampled synchronously to REF_CLK_I
// Notes: Data bus is two-way; DQ_OE_N_O low while driving
`timescale 1ns/10ps
`default_nettype none
// Operation
// R1 - Device pulls ready_busy_n low only while programming or erasing.
// R2 - Device only pulls ready_busy_n low; shared line uses pull-up.
// R3 - Ready_busy_n valid from final write strobe rising edge.
// R4 - Toggle_bit_one inverts on each read while algorithm runs.
// R5 - Toggle_bit_one readable anywhere, valid from final command write.
// R6 - All-protected erase toggles about 100 us then returns to read.
// R7 - Partly protected erase skips protected sectors silently.
// R8 - Protected program address toggles about 2 us then returns.
// R9 - Toggling stops in erase suspend, resumes for suspended program.
// R10 - Toggle_bit_two toggles in erase-selected sectors, not during program.
// R11 - Timeout_fail_bit set when pulse count limit exceeded.
// R12 - Programming a 0 back to 1 fails with timeout_fail_bit.
// R13 - Host issues reset command after a timeout failure.
// R14 - Reset command is one write of F0 to any address.
// R15 - Erase_timer_bit 0 in acceptance window, 1 after; chip erase exempt.
// R16 - Host may ignore erase_timer_bit only with commands under 50 us apart.
// R17 - Once erase_timer_bit is 1, only erase suspend accepted.
// R18 - Host confirms acceptance by polling before reading erase_timer_bit.
// R19 - Host reads twice, compares toggle bit; unchanged means done.
// R20 - Toggling with timeout_fail_bit set: recheck, then fail and reset.
// R21 - Resumed polling restarts from the first two reads.
// R22 - Host polls at a valid status address, rechecks after timeout.
// R23 - Program shows complement of programmed bit on polling_bit.
// R24 - Erase shows 0 on polling_bit until done or suspended.
// R25 - Busy reads give status; each read advances toggle once.
module fsr_poll_ctrl
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [3:0] ADR_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  output logic ACK_O,
  output logic [fsr_pkg::ADDR_W-1:0] FL_ADDR_O,
  input wire logic [fsr_pkg::DATA_W-1:0] FL_DQ_I,
  output logic [fsr_pkg::DATA_W-1:0] FL_DQ_O,
  output logic FL_DQ_OE_N_O,
  output logic FL_CHIP_SELECT_N_O,
  output logic FL_OUTPUT_STROBE_N_O,
  output logic FL_WRITE_STROBE_N_O,
  input wire logic FL_READY_BUSY_N_I
);
  import fsr_pkg::*;

  fsr_state_t state_reg;
  fsr_state_t ret_reg;
  logic [5:0] cnt_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] first_reg;
  logic [DATA_W-1:0] second_reg;
  logic done_reg;
  logic fail_reg;
  logic start_pulse;
  logic reset_pulse;
  logic wb_hit;

  function automatic logic toggled(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    toggled = a[TOGGLE_BIT_ONE] ^ b[TOGGLE_BIT_ONE];
  endfunction

  assign wb_hit = CYC_I && STB_I && !ACK_O;
  assign start_pulse = wb_hit && WE_I && SEL_I[0] && ADR_I == REG_CTRL && DAT_I[CTRL_START];
  assign reset_pulse = wb_hit && WE_I && SEL_I[0] && ADR_I == REG_CTRL
    && DAT_I[CTRL_RESET_CMD];

  // Wishbone slave: single-cycle ack, unmapped reads return zero
  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end
    else
    begin
      ACK_O <= wb_hit;
      DAT_O <= 32'h0000_0000;
      if (wb_hit && !WE_I)
      begin
        unique case (ADR_I)
          REG_ADDR: DAT_O <= {11'h000, addr_reg};
          // Raw status byte, erase timer included, is left to software
          REG_STAT: DAT_O <= {20'h00000, second_reg, (state_reg != ST_IDLE),
                              FL_READY_BUSY_N_I, fail_reg, done_reg}; // see R16, R18
          default: DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Status address; R22 leaves its choice to software
  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      addr_reg <= '0;
    else if (wb_hit && WE_I && ADR_I == REG_ADDR)
    begin
      if (SEL_I[0])
        addr_reg[7:0] <= DAT_I[7:0];
      if (SEL_I[1])
        addr_reg[15:8] <= DAT_I[15:8];
      // Top lane only carries the address bits that exist
      if (SEL_I[2])
        addr_reg[ADDR_W-1:16] <= DAT_I[ADDR_W-1:16];
    end
  end

  // Toggle-bit polling sequencer
  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state_reg <= ST_IDLE;
      ret_reg <= ST_IDLE;
      cnt_reg <= 6'h00;
      first_reg <= 8'h00;
      second_reg <= 8'h00;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      FL_ADDR_O <= '0;
      FL_DQ_O <= 8'h00;
      FL_DQ_OE_N_O <= 1'b1;
      FL_CHIP_SELECT_N_O <= 1'b1;
      FL_OUTPUT_STROBE_N_O <= 1'b1;
      FL_WRITE_STROBE_N_O <= 1'b1;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (start_pulse)
          begin
            // Every new start re-runs both reads
            done_reg <= 1'b0; // see R21
            fail_reg <= 1'b0;
            ret_reg <= ST_RD2;
            state_reg <= ST_RD1;
            cnt_reg <= STROBE_CNT;
            FL_ADDR_O <= addr_reg; // see R22
            FL_CHIP_SELECT_N_O <= 1'b0;
            FL_OUTPUT_STROBE_N_O <= 1'b0;
          end
          else if (reset_pulse)
          begin
            state_reg <= ST_WR;
            cnt_reg <= STROBE_CNT;
            FL_DQ_O <= RESET_CMD; // see R14
            FL_DQ_OE_N_O <= 1'b0;
            FL_CHIP_SELECT_N_O <= 1'b0;
            FL_WRITE_STROBE_N_O <= 1'b0;
          end
        end
        ST_RD1, ST_RD2, ST_RD3, ST_RD4:
        begin
          if (cnt_reg != 6'h00)
            cnt_reg <= cnt_reg - 6'h01;
          else
          begin
            // Sample at end of strobe, then release for one read per cycle
            first_reg <= (state_reg == ST_RD1 || state_reg == ST_RD3) ? FL_DQ_I : first_reg;
            second_reg <= (state_reg == ST_RD2 || state_reg == ST_RD4) ? FL_DQ_I : second_reg;
            FL_CHIP_SELECT_N_O <= 1'b1;
            FL_OUTPUT_STROBE_N_O <= 1'b1;
            ret_reg <= (state_reg == ST_RD1) ? ST_RD2 : (state_reg == ST_RD2) ? ST_CHECK
              : (state_reg == ST_RD3) ? ST_RD4 : ST_RECHECK;
            state_reg <= ST_GAP;
            cnt_reg <= STROBE_CNT;
          end
        end
        ST_GAP:
        begin
          if (cnt_reg != 6'h00)
            cnt_reg <= cnt_reg - 6'h01;
          else if (ret_reg == ST_CHECK || ret_reg == ST_RECHECK || ret_reg == ST_IDLE)
            state_reg <= ret_reg;
          else
          begin
            state_reg <= ret_reg;
            cnt_reg <= STROBE_CNT;
            FL_CHIP_SELECT_N_O <= 1'b0;
            FL_OUTPUT_STROBE_N_O <= 1'b0;
          end
        end
        ST_CHECK:
        begin
          if (!toggled(first_reg, second_reg))
          begin
            done_reg <= 1'b1; // see R19
            state_reg <= ST_IDLE;
          end
          else if (second_reg[TIMEOUT_FAIL_BIT])
          begin
            state_reg <= ST_RD3; // see R20
            cnt_reg <= STROBE_CNT;
            FL_CHIP_SELECT_N_O <= 1'b0;
            FL_OUTPUT_STROBE_N_O <= 1'b0;
          end
          else
          begin
            state_reg <= ST_RD1;
            cnt_reg <= STROBE_CNT;
            FL_CHIP_SELECT_N_O <= 1'b0;
            FL_OUTPUT_STROBE_N_O <= 1'b0;
          end
        end
        ST_RECHECK:
        begin
          if (!toggled(first_reg, second_reg))
          begin
            done_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
          else
          begin
            // Failure: flag fail as the reset command write starts; done follows the write
            fail_reg <= 1'b1; // see R13
            state_reg <= ST_WR;
            cnt_reg <= STROBE_CNT;
            FL_DQ_O <= RESET_CMD; // see R14
            FL_DQ_OE_N_O <= 1'b0;
            FL_CHIP_SELECT_N_O <= 1'b0;
            FL_WRITE_STROBE_N_O <= 1'b0;
          end
        end
        ST_WR:
        begin
          if (cnt_reg != 6'h00)
            cnt_reg <= cnt_reg - 6'h01;
          else
          begin
            if (fail_reg)
              done_reg <= 1'b1;
            FL_WRITE_STROBE_N_O <= 1'b1;
            FL_CHIP_SELECT_N_O <= 1'b1;
            FL_DQ_OE_N_O <= 1'b1;
            ret_reg <= ST_IDLE;
            state_reg <= ST_GAP;
            cnt_reg <= STROBE_CNT;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  AST_READ_STROBES_TOGETHER: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see R19
    FL_OUTPUT_STROBE_N_O == 1'b0 |-> FL_CHIP_SELECT_N_O == 1'b0 && FL_WRITE_STROBE_N_O)
    else $error("output strobe without chip select");
  AST_RESET_DATA: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see R14
    $fell(FL_WRITE_STROBE_N_O) |-> FL_DQ_O == RESET_CMD && !FL_DQ_OE_N_O)
    else $error("write is not the reset command");
  AST_FAIL_RESETS: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see R13
    $rose(fail_reg) |-> !FL_WRITE_STROBE_N_O)
    else $error("failure without reset write");
  AST_RECHECK_AFTER_TIMEOUT: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see R20
    state_reg == ST_CHECK && toggled(first_reg, second_reg) && second_reg[TIMEOUT_FAIL_BIT]
    |=> state_reg == ST_RD3)
    else $error("no recheck after timeout bit");
  AST_DONE_ON_STABLE: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see R19
    state_reg == ST_CHECK && !toggled(first_reg, second_reg) |=> done_reg && !fail_reg)
    else $error("stable toggle bit not reported done");
  AST_RESTART: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see R21
    state_reg == ST_IDLE && start_pulse |=> state_reg == ST_RD1 && !done_reg)
    else $error("polling did not restart from first read");
  AST_NO_DRIVE_ON_READ: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see R19
    !FL_OUTPUT_STROBE_N_O |-> FL_DQ_OE_N_O)
    else $error("bus driven during read");
  AST_ADDR_STABLE: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // see R22
    !FL_CHIP_SELECT_N_O && !$past(FL_CHIP_SELECT_N_O) |-> $stable(FL_ADDR_O))
    else $error("address moved during cycle");
  COV_DONE: cover property (@(posedge REF_CLK_I) disable iff (RST_I) $rose(done_reg));
  COV_FAIL: cover property (@(posedge REF_CLK_I) disable iff (RST_I) $rose(fail_reg));
  COV_RECHECK: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_reg == ST_RECHECK);
endmodule
`default_nettype wire

// ==== tb/fsr_flash_model.sv ====
// Purpose: Flash status side of the poll controller bench
// Assumes: A read is chip select and output strobe low, write strobe high
// Notes: Modes 0 program, 1 timeout, 2 late stop, 3 erase; idle bus shows ~last byte
`timescale 1ns/10ps
`default_nettype none
module fsr_flash_model
(
  input wire logic cs_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [7:0] dq_i,
  input wire logic arm_i,
  input wire logic [3:0] left_i,
  input wire logic [1:0] mode_i,
  input wire logic [7:0] arr_i,
  output logic [7:0] dq_o,
  output logic rb_oe_n_o,
  output var int resets_o
);
  logic busy = 0;
  logic tog = 0;
  logic tog2 = 0;
  logic fl = 0;
  logic stop = 0;
  logic seen = 0;
  int left = 0;
  logic [7:0] last = 8'h00;
  logic [7:0] sts;
  wire logic rd = !cs_n_i && !oe_n_i && we_n_i;
  wire logic wr = !cs_n_i && !we_n_i;
  wire logic erase = mode_i == 2'd3;
  // Pulls low only, never drives high
  assign rb_oe_n_o = !busy;
  // Erase timer window taken as already expired when polling starts
  assign sts = {erase ? 1'b0 : ~arr_i[7], tog, fl, 1'b0, erase,
    erase && tog2, 2'b00};
  assign dq_o = rd ? (busy ? sts : arr_i) : ~last;
  initial resets_o = 0;
  always @(posedge arm_i)
  begin
    busy = 1;
    left = left_i;
    fl = 0;
    stop = 0;
  end
  always @(posedge rd)
  begin
    if (busy)
    begin
      if (!stop)
        tog = !tog;
      tog2 = !tog2;
      if (left > 0)
        left--;
      else if (mode_i == 2'd1 || mode_i == 2'd2)
      begin
        fl = 1;
        // Mode 2 stops toggling just as the fail bit rises
        stop = mode_i == 2'd2;
      end
    end
  end
  // Short busy spell, then back to array data with no error flagged
  always @(negedge rd)
    if (busy && left == 0 && (mode_i == 2'd0 || erase))
      busy = 0;
  always @(dq_o)
    if (rd)
      last = dq_o;
  always @(dq_i or wr)
    if (wr && dq_i == 8'hF0)
      seen = 1;
  always @(negedge wr)
  begin
    // A running erase takes no command but suspend
    if (seen && !(erase && busy))
    begin
      busy = 0;
      fl = 0;
      stop = 0;
      resets_o++;
    end
    seen = 0;
  end
endmodule
`default_nettype wire

// ==== tb/flash_write_status_reporting_test.sv ====
// Purpose: Self-checking bench for the toggle-bit poll controller
// Assumes: Flash model on the far side, pull-up on ready/busy
// Notes: Random array bytes and busy lengths from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module flash_write_status_reporting_test;
  import fsr_pkg::*;
  logic clk, rst, we, cyc, stb, arm, ack;
  logic [3:0] adr, left;
  logic [1:0] mode;
  logic [7:0] arr;
  logic [31:0] dw, dr, q;
  wire logic [20:0] fa;
  wire logic [7:0] dqo, dqm, line;
  wire logic oe_n, cs_n, os_n, ws_n, rbo;
  int errors = 0;
  int checks = 0;
  int resets;
  assign line = oe_n ? dqm : dqo;
  fsr_poll_ctrl u_fsr_poll_ctrl (.REF_CLK_I(clk), .RST_I(rst), .ADR_I(adr), .DAT_I(dw),
    .DAT_O(dr), .WE_I(we), .SEL_I(4'hF), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack),
    .FL_ADDR_O(fa), .FL_DQ_I(line), .FL_DQ_O(dqo), .FL_DQ_OE_N_O(oe_n),
    .FL_CHIP_SELECT_N_O(cs_n), .FL_OUTPUT_STROBE_N_O(os_n),
    .FL_WRITE_STROBE_N_O(ws_n), .FL_READY_BUSY_N_I(rbo));
  fsr_flash_model u_fsr_flash_model (.cs_n_i(cs_n), .oe_n_i(os_n), .we_n_i(ws_n),
    .dq_i(line), .arm_i(arm), .left_i(left), .mode_i(mode), .arr_i(arr), .dq_o(dqm),
    .rb_oe_n_o(rbo), .resets_o(resets));
  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Held until ack is sampled high, released after
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    we <= w;
    dw <= d;
    cyc <= 1;
    stb <= 1;
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dr;
    if (n >= 50)
    begin
      errors++;
      results();
    end
    cyc <= 0;
    stb <= 0;
  endtask
  function automatic logic [31:0] stat(input logic f, input logic [7:0] b);
    return {20'h0, b, 1'b0, 1'b1, f, 1'b1};
  endfunction
  task automatic run(input logic [3:0] l, input logic [1:0] m, input logic f);
    int n;
    int r;
    logic [31:0] a;
    arr <= 8'($urandom);
    left <= l;
    mode <= m;
    a = $urandom & 32'h001F_FFFF;
    r = resets;
    wb(REG_ADDR, 1, a);
    wb(REG_ADDR, 0, 0);
    check("addr_rb", q, a);
    // Model settings are already in place when it is armed
    arm <= 1;
    if (f)
    begin
      wb(REG_CTRL, 1, 32'h2);
      arm <= 0;
      repeat (60) @(posedge clk);
      check("erase_f0", resets, r);
    end
    wb(REG_CTRL, 1, 32'h1);
    arm <= 0;
    wb(REG_STAT, 0, 0);
    check("busy_rb", q[3:2], 2'b10);
    check("fl_addr", fa, a);
    n = 0;
    // Done can show while the gap after the closing reset write still runs
    do
    begin
      wb(REG_STAT, 0, 0);
      n++;
    end while ((q[0] !== 1'b1 || q[3] !== 1'b0) && n < 2000);
    if (n >= 2000)
    begin
      errors++;
      results();
    end
    $display("test mode %0d busy %0d done", m, l);
  endtask
  initial
  begin
    rst = 1;
    {cyc, stb, we, arm, adr, dw, left, mode, arr} = '0;
    void'($urandom(32'h2a20));
    repeat (2) @(posedge clk);
    rst <= 0;
    wb(REG_STAT, 0, 0);
    check("stat_reset", q, 32'h0000_0004);
    wb(4'hC, 0, 0);
    check("unmapped", q, 0);
    $display("test reset state done");
    run(0, 0, 0);
    check("prog_short", q, stat(0, arr));
    repeat (4)
    begin
      run(4'($urandom_range(1, 6)), 0, 0);
      check("prog", q, stat(0, arr));
    end
    run(2, 1, 0);
    check("fail", q[3:0], 4'b0111);
    check("auto_f0", resets, 1);
    run(4'($urandom_range(1, 6)), 3, 1);
    check("erase", q, stat(0, arr));
    run(1, 2, 0);
    check("late_stop", q[3:0], 4'b0001);
    wb(REG_CTRL, 1, 32'h2);
    repeat (60) @(posedge clk);
    wb(REG_STAT, 0, 0);
    check("cmd_f0", resets, 2);
    check("ready", q[2], 1'b1);
    $display("test reset command done");
    results();
  end
endmodule
`default_nettype wire
